// ---- hw/gsf_pkg.sv ----
package gsf_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [6:0] GSF_ADDR_GEN = 7'h21;
  localparam logic [15:0] GSF_RESET_VAL = 16'h1180;
  localparam logic [15:0] GSF_IRQ_MASK_RST = 16'h0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int GSF_B_ALARM_IRQ = 15;
  localparam int GSF_B_MODEM_IRQ = 14;
  localparam int GSF_B_TRIM_BUSY = 12;
  localparam int GSF_B_MT_DONE = 10;
  localparam int GSF_B_MT_FAIL = 9;
  localparam int GSF_B_RESET = 8;
  localparam int GSF_B_SLEW = 7;
  localparam int GSF_B_EOC = 6;
  localparam int GSF_B_CONV_BUSY = 5;
  localparam int GSF_B_SUPPLY = 4;
  localparam int GSF_B_BRK_FRAME = 3;
  localparam int GSF_B_BRK_PAR = 2;
  localparam int GSF_B_CHR_FRAME = 1;
  localparam int GSF_B_CHR_PAR = 0;

  // Bits that may feed the interrupt (maskable sources)
  localparam logic [15:0] GSF_IRQ_SRC = 16'h06CF;

  // Settle time with slew limiting off
  localparam int GSF_SETTLE_CYC = 3;

  // Event inputs, one-cycle pulses
  typedef struct packed {
    logic memtest_complete;
    logic memtest_failed;
    logic conv_done;
    logic brk_frame_err;
    logic brk_parity_err;
    logic chr_frame_err;
    logic chr_parity_err;
  } gsf_evt_t;

  // Register access strobes
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
  } gsf_acc_t;

endpackage

// ---- hw/gsf_status_reg.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Bit 15 ORs unmasked alarm flags
// - Bit 14 ORs unmasked modem flags
// - Bit 12 high until trim copy done
// - Bit 10 sticky on memtest completion
// - Bit 9 sticky on memtest failure
// - Bit 8 set after reset, no interrupt
// - Sticky flags clear on read unless persisting
// - Bit 7 high once output reaches target
// - Settled within 3 cycles without slewing
// - Interrupt event when slewed output settles
// - Bit 6 sticky on conversion end
// - Bit 5 live conversion busy, no interrupt
// - Bit 4 live supply level, no interrupt
// - Bit 3 sticky break stop-bit error
// - Bit 2 sticky break parity error
// - Bit 1 sticky character stop-bit error
// - Bit 0 sticky character parity error
module gsf_status_reg
  import gsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire gsf_acc_t acc,
  output logic [15:0] rdata,
  output logic rvalid,
  input wire logic [15:0] alarm_flags,
  input wire logic [15:0] alarm_mask,
  input wire logic [15:0] modem_flags,
  input wire logic [15:0] modem_mask,
  input wire logic trim_done,
  input wire gsf_evt_t evt,
  input wire logic memtest_fail_level,
  input wire logic slew_enable,
  input wire logic target_load,
  input wire logic slew_at_target,
  input wire logic conv_busy,
  input wire logic supply_high,
  input wire logic [15:0] irq_mask,
  output logic slew_settled,
  output logic slew_event,
  output logic irq
);

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic rd_hit;
  assign rd_hit = acc.rd && (acc.addr == GSF_ADDR_GEN);

  // ------------------------------------------------------------
  // Trim load progress
  // ------------------------------------------------------------
  logic trim_busy_q;

  // Once done, stays done until the next reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trim_busy_q <= 1'b1;
    else if (trim_done)
      trim_busy_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Slew settled tracking
  // ------------------------------------------------------------
  logic [1:0] settle_cnt_q;
  logic settled_q;
  logic settled_d;

  // Without slewing the target is forced through in a fixed delay
  always_comb
  begin
    settled_d = settled_q;
    if (target_load)
      settled_d = 1'b0;
    else if (slew_enable && slew_at_target)
      settled_d = 1'b1;
    else if (!slew_enable && settle_cnt_q >= 2'(GSF_SETTLE_CYC - 1))
      settled_d = 1'b1;
  end

  // Settle count restarts from zero on every new target
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settle_cnt_q <= 2'h0;
    else if (target_load)
      settle_cnt_q <= 2'h0;
    else if (!settled_q && settle_cnt_q != 2'h3)
      settle_cnt_q <= settle_cnt_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settled_q <= GSF_RESET_VAL[GSF_B_SLEW];
    else
      settled_q <= settled_d;
  end

  // Event only on the slewed arrival; host may then turn slewing off
  assign slew_event = slew_enable && !settled_q && settled_d;
  assign slew_settled = settled_q;

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  logic [15:0] set_vec;
  logic [15:0] hold_vec;
  logic [15:0] sticky_q;
  localparam logic [15:0] STICKY_BITS = 16'h074F;

  // Set sources; hold keeps a flag whose condition still stands
  always_comb
  begin
    set_vec = 16'h0000;
    hold_vec = 16'h0000;
    set_vec[GSF_B_MT_DONE] = evt.memtest_complete;
    set_vec[GSF_B_MT_FAIL] = evt.memtest_failed;
    hold_vec[GSF_B_MT_FAIL] = memtest_fail_level;
    set_vec[GSF_B_EOC] = evt.conv_done;
    set_vec[GSF_B_BRK_FRAME] = evt.brk_frame_err;
    set_vec[GSF_B_BRK_PAR] = evt.brk_parity_err;
    set_vec[GSF_B_CHR_FRAME] = evt.chr_frame_err;
    set_vec[GSF_B_CHR_PAR] = evt.chr_parity_err;
  end

  // Set beats the clear-on-read so no event is lost; writes never touch it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sticky_q <= GSF_RESET_VAL & STICKY_BITS;
    else if (rd_hit)
      sticky_q <= (set_vec | hold_vec) & STICKY_BITS;
    else
      sticky_q <= (sticky_q | set_vec | hold_vec) & STICKY_BITS;
  end

  // ------------------------------------------------------------
  // Assembled word
  // ------------------------------------------------------------
  logic [15:0] word;

  // Live bits and summaries; bits 13 and 11 stay zero
  always_comb
  begin
    word = sticky_q;
    word[GSF_B_ALARM_IRQ] = |(alarm_flags & ~alarm_mask);
    word[GSF_B_MODEM_IRQ] = |(modem_flags & ~modem_mask);
    word[GSF_B_TRIM_BUSY] = trim_busy_q;
    word[GSF_B_SLEW] = settled_q;
    word[GSF_B_CONV_BUSY] = conv_busy;
    word[GSF_B_SUPPLY] = supply_high;
  end

  // Read data is the pre-clear snapshot, held until the next read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 16'h0000;
    else if (rd_hit)
      rdata <= word;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rvalid <= 1'b0;
    else
      rvalid <= rd_hit;
  end

  // Maskable sources and the unmaskable slew_event reach the interrupt; reset/busy/supply excluded
  assign irq = |(word & GSF_IRQ_SRC & ~irq_mask) || slew_event;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_read_clears_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit && !evt.chr_parity_err ##1 !evt.chr_parity_err |-> !sticky_q[GSF_B_CHR_PAR])
    else $error("parity flag not cleared by read");

  a_event_survives_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit && evt.conv_done |=> sticky_q[GSF_B_EOC])
    else $error("event lost on read");

  a_read_pre_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit |=> rdata == $past(word))
    else $error("read data not pre-clear value");

  a_settle_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    target_load && !slew_enable ##1 (!slew_enable && !target_load)[*3]
    |=> slew_settled)
    else $error("settled not within bound");

  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    rvalid |-> rdata[13] == 1'b0 && rdata[11] == 1'b0)
    else $error("reserved bit set");

  a_write_no_effect: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc.wr && !acc.rd && set_vec == 16'h0000 && hold_vec == 16'h0000
    |=> sticky_q == $past(sticky_q))
    else $error("write changed flags");

  a_alarm_summary: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit && |(alarm_flags & ~alarm_mask) |=> rdata[GSF_B_ALARM_IRQ])
    else $error("alarm summary wrong");

  a_trim_done_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    trim_done |=> !trim_busy_q [*2])
    else $error("trim busy returned");

  // ------------------------------------------------------------
  // Checks: summaries, trim and live bits
  // ------------------------------------------------------------
  // Any unmasked modem flag must show up in the read word
  a_modem_summary: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit && |(modem_flags & ~modem_mask) |=> rdata[GSF_B_MODEM_IRQ])
    else $error("modem summary wrong");

  // Trim busy only moves when the copy reports done
  a_trim_busy_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !trim_done |=> trim_busy_q == $past(trim_busy_q))
    else $error("trim busy moved without done");

  // Conversion busy is taken live at the read edge
  a_conv_busy_live: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit |=> rdata[GSF_B_CONV_BUSY] == $past(conv_busy))
    else $error("conversion busy not live");

  // Supply level is taken live at the read edge
  a_supply_live: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit |=> rdata[GSF_B_SUPPLY] == $past(supply_high))
    else $error("supply level not live");

  // ------------------------------------------------------------
  // Checks: sticky flags
  // ------------------------------------------------------------
  // Reset flag stands at the first edge after any reset
  a_reset_flag_up: assert property (
    @(posedge clk)
    $rose(rst_n) |-> sticky_q[GSF_B_RESET])
    else $error("reset flag missing after reset");

  // With every real source masked, the reset flag alone keeps irq low
  a_reset_no_irq: assert property (
    @(posedge clk) disable iff (!rst_n)
    (irq_mask | 16'h0100) == 16'hFFFF && !slew_event |-> !irq)
    else $error("reset flag reached irq");

  // Memory test completion sets its flag
  a_memtest_done_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.memtest_complete |=> sticky_q[GSF_B_MT_DONE])
    else $error("memtest done flag not set");

  // Memory test failure sets its flag
  a_memtest_fail_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.memtest_failed |=> sticky_q[GSF_B_MT_FAIL])
    else $error("memtest fail flag not set");

  // A failure still present survives the clearing read
  a_fail_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit && memtest_fail_level |=> sticky_q[GSF_B_MT_FAIL])
    else $error("persisting failure cleared");

  // Without a read no sticky flag may drop
  a_sticky_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rd_hit |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
    else $error("sticky flag dropped without read");

  // End of conversion sets its flag
  a_eoc_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.conv_done |=> sticky_q[GSF_B_EOC])
    else $error("end of conversion flag not set");

  // Break stop-bit error sets its flag
  a_brk_frame_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.brk_frame_err |=> sticky_q[GSF_B_BRK_FRAME])
    else $error("break frame flag not set");

  // Break parity error sets its flag
  a_brk_par_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.brk_parity_err |=> sticky_q[GSF_B_BRK_PAR])
    else $error("break parity flag not set");

  // Character stop-bit error sets its flag
  a_chr_frame_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.chr_frame_err |=> sticky_q[GSF_B_CHR_FRAME])
    else $error("character frame flag not set");

  // Character parity error sets its flag
  a_chr_par_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.chr_parity_err |=> sticky_q[GSF_B_CHR_PAR])
    else $error("character parity flag not set");

  // ------------------------------------------------------------
  // Checks: slew and access
  // ------------------------------------------------------------
  // Slewed output at target settles on the next edge
  a_settled_target: assert property (
    @(posedge clk) disable iff (!rst_n)
    slew_enable && slew_at_target && !target_load |=> slew_settled)
    else $error("slewed output not settled");

  // The slew event is followed by the settled bit
  a_slew_event_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    slew_event |=> slew_settled)
    else $error("slew event without settle");

  // Every read hit is answered on the next edge
  a_rvalid_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_hit |=> rvalid)
    else $error("read not answered");

  // Writes and other offsets get no answer
  a_refused_silent: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rd_hit |=> !rvalid)
    else $error("refused access answered");

endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import gsf_pkg::*;
;
  logic clk, rst_n, trim_done, mt_lvl, slew_en, tload, at_tgt, busy, sup;
  logic [15:0] af, am, mf, mm, rdata, imask;
  logic rvalid, settled, sev, irq_o;
  gsf_acc_t acc;
  gsf_evt_t evt;
  int error_cnt = 0;
  int check_count = 0;

  gsf_status_reg u_gsf_status_reg (.clk(clk), .rst_n(rst_n), .acc(acc), .rdata(rdata),
    .rvalid(rvalid), .alarm_flags(af), .alarm_mask(am), .modem_flags(mf), .modem_mask(mm),
    .trim_done(trim_done), .evt(evt), .memtest_fail_level(mt_lvl), .slew_enable(slew_en),
    .target_load(tload), .slew_at_target(at_tgt), .conv_busy(busy), .supply_high(sup),
    .irq_mask(imask), .slew_settled(settled), .slew_event(sev), .irq(irq_o));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One read; rdata is judged in the cycle rvalid stands
  task automatic rd(input logic [15:0] exp);
    @(posedge clk) acc <= '{1'b1, 1'b0, GSF_ADDR_GEN};
    @(posedge clk) acc <= '0;
    #1 chk({15'h0, rvalid}, 16'h0001, "rvalid");
    chk(rdata, exp, "read data");
    @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(16'h1180);
    trim_done <= 1'b1;
    rd(16'h0080);
    $display("test reset done");
  endtask

  // Events, also one landing on the same edge as a read
  task automatic t_events();
    @(posedge clk) evt <= '1;
    @(posedge clk) evt <= '0;
    rd(16'h06CF);
    rd(16'h0080);
    @(posedge clk) acc <= '{1'b1, 1'b0, GSF_ADDR_GEN};
    evt <= '1;
    @(posedge clk) acc <= '0;
    evt <= '0;
    #1 chk(rdata, 16'h0080, "pre-clear value");
    rd(16'h06CF);
    $display("test events done");
  endtask

  // Failure condition still present keeps bit 9 through reads
  task automatic t_persist();
    @(posedge clk) mt_lvl <= 1'b1;
    evt <= 7'h20;
    @(posedge clk) evt <= '0;
    rd(16'h0280);
    rd(16'h0280);
    mt_lvl <= 1'b0;
    rd(16'h0280);
    rd(16'h0080);
    $display("test persist done");
  endtask

  // Live bits, summary ORs, refused accesses
  task automatic t_live();
    @(posedge clk) af <= 16'h0010;
    mf <= 16'h0001;
    mm <= 16'h0001;
    busy <= 1'b1;
    sup <= 1'b1;
    imask <= 16'h0080;
    acc <= '{1'b0, 1'b1, GSF_ADDR_GEN};
    @(posedge clk) acc <= '{1'b1, 1'b0, 7'h22};
    @(posedge clk) acc <= '0;
    #1 chk({15'h0, rvalid}, 16'h0000, "refused access");
    chk({15'h0, irq_o}, 16'h0000, "status bits irq");
    rd(16'h80B0);
    mm <= 16'h0000;
    am <= 16'h0010;
    busy <= 1'b0;
    sup <= 1'b0;
    rd(16'h4080);
    mf <= 16'h0000;
    rd(16'h0080);
    imask <= 16'h0000;
    @(posedge clk) #1 chk({15'h0, irq_o}, 16'h0001, "settled irq");
    $display("test live done");
  endtask

  // Settling without and with slew limiting
  task automatic t_slew();
    @(posedge clk) tload <= 1'b1;
    @(posedge clk) tload <= 1'b0;
    #1 chk({15'h0, settled}, 16'h0000, "settling");
    repeat (3) @(posedge clk);
    #1 chk({15'h0, settled}, 16'h0001, "settled");
    @(posedge clk) slew_en <= 1'b1;
    tload <= 1'b1;
    @(posedge clk) tload <= 1'b0;
    rd(16'h0000);
    @(posedge clk) at_tgt <= 1'b1;
    #1 chk({15'h0, sev}, 16'h0001, "slew event");
    @(posedge clk) #1 chk({15'h0, settled}, 16'h0001, "slewed settle");
    rd(16'h0080);
    slew_en <= 1'b0;
    $display("test slew done");
  endtask

  // Mid-run reset restores the reset flag, which never raises irq
  task automatic t_rereset();
    @(posedge clk) rst_n <= 1'b0;
    trim_done <= 1'b0;
    imask <= 16'h0080;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({15'h0, irq_o}, 16'h0000, "reset flag irq");
    rd(16'h1180);
    evt <= 7'h10;
    @(posedge clk) evt <= '0;
    #1 chk({15'h0, irq_o}, 16'h0001, "conversion end irq");
    rd(16'h10C0);
    $display("test rereset done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    acc = '0;
    evt = '0;
    {trim_done, mt_lvl, slew_en, tload, at_tgt, busy, sup} = '0;
    {af, am, mf, mm} = '0;
    imask = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_events();
    t_persist();
    t_live();
    t_slew();
    t_rereset();
    complete_run();
  end

  // Whole run is well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
